// ==== rtl/cwp_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------------
// configuration word protection decode: shared constants
// ----------------------------------------------------------------------
package cwp_pkg;
  localparam int WORD_W = 14;
  // register indexes; byte address is four times the index
  localparam logic [15:0] REV_IDX = 16'h8005;
  localparam logic [15:0] ID_IDX = 16'h8006;
  localparam logic [15:0] WP_IDX = 16'h800A;
  localparam logic [15:0] CP_IDX = 16'h800B;
  localparam logic [15:0] WDT_IDX = 16'h8010;
  localparam logic [15:0] ERASE_IDX = 16'h8011;
  // write_protect_partition_word fields
  localparam int LVP_BIT = 13;
  localparam int SAF_WP_BIT = 11;
  localparam int EE_WP_BIT = 10;
  localparam int CFG_WP_BIT = 9;
  localparam int BB_WP_BIT = 8;
  localparam int APP_WP_BIT = 7;
  localparam int SAF_EN_N_BIT = 4;
  localparam int BB_EN_N_BIT = 3;
  localparam int BB_SIZE_MSB = 2;
  // code_protect_word field
  localparam int CP_BIT = 0;
  // bits that may only go from 1 to 0 outside a bulk erase
  localparam logic [13:0] WP_STICKY_MASK = 14'h0F98;
  localparam logic [13:0] CP_STICKY_MASK = 14'h0001;
  // erased state of the nonvolatile words
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [4:0] WDT_ERASED = 5'h1F;
  // erase command bit
  localparam int ERASE_GO_BIT = 0;
  // watchdog period select decode
  localparam logic [4:0] WDT_LAST_SCALED = 5'h12;
  localparam logic [4:0] WDT_BASE_LOG2 = 5'h05;
  localparam logic [4:0] WDT_SW_CODE = 5'h1F;
  localparam logic [4:0] WDT_SW_LOG2 = 5'h10;
  // boot block size decode
  localparam logic [2:0] BB_CODE_512 = 3'h7;
  localparam logic [2:0] BB_CODE_1K = 3'h6;
  localparam logic [15:0] BB_WORDS_512 = 16'h0200;
  localparam logic [15:0] BB_WORDS_1K = 16'h0400;
  localparam logic [15:0] BB_WORDS_2K = 16'h0800;
  // fixed marker bits 13:12 of the read-only words
  localparam logic [1:0] REV_MARK = 2'h2;
  localparam logic [1:0] ID_MARK = 2'h3;
endpackage
`default_nettype wire

// ==== rtl/cwp_wdt_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// watchdog period select decode
// ----------------------------------------------------------------------
module cwp_wdt_decode (
  input wire logic [4:0] period_code, // watchdog_period_select_cfg
  output logic [4:0] divider_log2, // divider is two to this power
  output logic sw_control // software may change the live select
);
  wire logic scaled = (period_code <= cwp_pkg::WDT_LAST_SCALED);
  wire logic sw_code = (period_code == cwp_pkg::WDT_SW_CODE);
  wire logic [4:0] scaled_log2 = 5'(period_code + cwp_pkg::WDT_BASE_LOG2);

  // codes past the scaled range, other than the software code, fall back to the shortest divider
  assign divider_log2 = scaled ? scaled_log2 :
    (sw_code ? cwp_pkg::WDT_SW_LOG2 : cwp_pkg::WDT_BASE_LOG2);
  assign sw_control = sw_code;
endmodule // cwp_wdt_decode
`default_nettype wire

// ==== rtl/cwp_config_protect.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cwp_config_protect #(
  parameter int PROG_WORDS = 4096, // implemented user program words
  parameter logic [5:0] MAJOR_REV = 6'h01, // arbitrary value
  parameter logic [5:0] MINOR_REV = 6'h00, // arbitrary value
  parameter logic [11:0] PART_CODE = 12'h5A1 // arbitrary value
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [17:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic lvp_session, // low-voltage programming active
  input wire logic core_reset_hold, // device reset in progress
  input wire logic external_reset_pin_enable, // cfg bit, other word
  output logic external_reset_input_sel, // pin acts as reset
  output logic hv_program_entry_required, // programmer must use hv
  output logic storage_area_write_protected, // saf locked
  output logic eeprom_write_protected, // data eeprom locked
  output logic config_write_protected, // config words locked
  output logic boot_block_write_protected, // boot block locked
  output logic application_write_protected, // app block locked
  output logic storage_area_enabled, // saf partition present
  output logic boot_block_enabled, // boot partition present
  output logic [15:0] boot_block_words, // boot block size in words
  output logic [15:0] boot_block_last_addr, // last boot word address
  output logic code_protect_enabled, // program flash code protect
  output logic [4:0] watchdog_divider_log2, // watchdog divider exponent
  output logic watchdog_sw_control // software may set live period
);
  localparam logic [15:0] HALF_WORDS = 16'(PROG_WORDS / 2);

  // ----------------------------------------------------------------------
  // stored words, their latched copies and apb decode
  // ----------------------------------------------------------------------
  logic [13:0] stored_wp, stored_cp, act_wp, act_cp, next_wp, next_cp;
  logic [4:0] stored_wdt, act_wdt;
  logic [13:0] rd_word;

  // address decode
  wire logic hit_rev = (paddr == {cwp_pkg::REV_IDX, 2'b00});
  wire logic hit_id = (paddr == {cwp_pkg::ID_IDX, 2'b00});
  wire logic hit_wp = (paddr == {cwp_pkg::WP_IDX, 2'b00});
  wire logic hit_cp = (paddr == {cwp_pkg::CP_IDX, 2'b00});
  wire logic hit_wdt = (paddr == {cwp_pkg::WDT_IDX, 2'b00});
  wire logic hit_erase = (paddr == {cwp_pkg::ERASE_IDX, 2'b00});
  wire logic hit_any = hit_rev | hit_id | hit_wp | hit_cp | hit_wdt | hit_erase;
  wire logic cfg_target = hit_wp | hit_cp | hit_wdt;
  wire logic cfg_locked = ~stored_wp[cwp_pkg::CFG_WP_BIT];
  wire logic ro_write = pwrite & (hit_rev | hit_id);
  wire logic bad = ~hit_any | ro_write | (pwrite & cfg_target & cfg_locked);
  wire logic setup = psel & ~penable;
  wire logic done = psel & penable & pready;
  wire logic do_write = done & pwrite & ~bad;
  wire logic wr_wp = do_write & hit_wp;
  wire logic wr_cp = do_write & hit_cp;
  wire logic wr_wdt = do_write & hit_wdt;
  wire logic erase_go = do_write & hit_erase & pwdata[cwp_pkg::ERASE_GO_BIT];
  wire logic [13:0] wd14 = pwdata[13:0];

  // write merge: protection bits can only be programmed toward protected
  always_comb begin
    next_wp = stored_wp & (wd14 | ~cwp_pkg::WP_STICKY_MASK);
    next_wp[cwp_pkg::LVP_BIT] = stored_wp[cwp_pkg::LVP_BIT] &
      (wd14[cwp_pkg::LVP_BIT] | lvp_session);
    // size field follows the stored enable seen before this write
    next_wp[cwp_pkg::BB_SIZE_MSB:0] = stored_wp[cwp_pkg::BB_EN_N_BIT] ?
      wd14[cwp_pkg::BB_SIZE_MSB:0] : stored_wp[cwp_pkg::BB_SIZE_MSB:0];
    next_cp = stored_cp & (wd14 | ~cwp_pkg::CP_STICKY_MASK);
  end

  // read mux; unimplemented bits of the wp and cp words read as 1, of the watchdog word as 0
  assign rd_word = hit_rev ? {cwp_pkg::REV_MARK, MAJOR_REV, MINOR_REV} :
    hit_id ? {cwp_pkg::ID_MARK, PART_CODE} :
    hit_wp ? stored_wp :
    hit_cp ? stored_cp :
    hit_wdt ? {9'h000, stored_wdt} : 14'h0000;

  // ----------------------------------------------------------------------
  // nonvolatile stand-ins: a bulk erase or presetn returns them all to erased
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_wp <= cwp_pkg::ERASED_WORD;
      stored_cp <= cwp_pkg::ERASED_WORD;
      stored_wdt <= cwp_pkg::WDT_ERASED;
    end else if (erase_go) begin
      stored_wp <= cwp_pkg::ERASED_WORD;
      stored_cp <= cwp_pkg::ERASED_WORD;
      stored_wdt <= cwp_pkg::WDT_ERASED;
    end else begin
      if (wr_wp) stored_wp <= next_wp;
      if (wr_cp) stored_cp <= next_cp;
      if (wr_wdt) stored_wdt <= pwdata[4:0];
    end
  end

  // latched copies reload only while the device sits in reset, so a
  // running program never sees a half-programmed word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_wp <= cwp_pkg::ERASED_WORD;
      act_cp <= cwp_pkg::ERASED_WORD;
      act_wdt <= cwp_pkg::WDT_ERASED;
    end else if (core_reset_hold) begin
      act_wp <= stored_wp;
      act_cp <= stored_cp;
      act_wdt <= stored_wdt;
    end
  end

  // apb answer: ready in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & bad;
      if (setup) prdata <= (pwrite | bad) ? 32'h0000_0000 : {18'h00000, rd_word};
    end
  end

  // ----------------------------------------------------------------------
  // decode from the latched copies
  // ----------------------------------------------------------------------
  logic [15:0] bb_sel_words, bb_cap_words, bb_words;
  logic [4:0] wdt_log2;
  logic wdt_sw;
  wire logic bb_en_n = act_wp[cwp_pkg::BB_EN_N_BIT];
  wire logic [2:0] bb_code = act_wp[cwp_pkg::BB_SIZE_MSB:0];

  cwp_wdt_decode u_wdt_decode (
    .period_code (act_wdt),
    .divider_log2 (wdt_log2),
    .sw_control (wdt_sw)
  );

  assign bb_sel_words = (bb_code == cwp_pkg::BB_CODE_512) ? cwp_pkg::BB_WORDS_512 :
    (bb_code == cwp_pkg::BB_CODE_1K) ? cwp_pkg::BB_WORDS_1K : cwp_pkg::BB_WORDS_2K;
  // small parts cannot hold a 2k boot block; clamp instead of wrapping
  assign bb_cap_words = (bb_sel_words > HALF_WORDS) ? HALF_WORDS : bb_sel_words;
  assign bb_words = bb_en_n ? 16'h0000 : bb_cap_words;

  // outputs registered from the decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_reset_input_sel <= 1'b1;
      hv_program_entry_required <= 1'b0;
      storage_area_write_protected <= 1'b0;
      eeprom_write_protected <= 1'b0;
      config_write_protected <= 1'b0;
      boot_block_write_protected <= 1'b0;
      application_write_protected <= 1'b0;
      storage_area_enabled <= 1'b0;
      boot_block_enabled <= 1'b0;
      boot_block_words <= 16'h0000;
      boot_block_last_addr <= 16'h0000;
      code_protect_enabled <= 1'b0;
      watchdog_divider_log2 <= cwp_pkg::WDT_SW_LOG2;
      watchdog_sw_control <= 1'b1;
    end else begin
      external_reset_input_sel <= act_wp[cwp_pkg::LVP_BIT] |
        external_reset_pin_enable;
      hv_program_entry_required <= ~act_wp[cwp_pkg::LVP_BIT];
      storage_area_write_protected <= ~act_wp[cwp_pkg::SAF_WP_BIT];
      eeprom_write_protected <= ~act_wp[cwp_pkg::EE_WP_BIT];
      config_write_protected <= ~act_wp[cwp_pkg::CFG_WP_BIT];
      boot_block_write_protected <= ~act_wp[cwp_pkg::BB_WP_BIT];
      application_write_protected <= ~act_wp[cwp_pkg::APP_WP_BIT];
      storage_area_enabled <= ~act_wp[cwp_pkg::SAF_EN_N_BIT];
      boot_block_enabled <= ~bb_en_n;
      boot_block_words <= bb_words;
      boot_block_last_addr <= bb_en_n ? 16'h0000 : 16'(bb_cap_words - 16'h0001);
      code_protect_enabled <= ~act_cp[cwp_pkg::CP_BIT];
      watchdog_divider_log2 <= wdt_log2;
      watchdog_sw_control <= wdt_sw;
    end
  end

  // ----------------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wdt_short_a: assert property ((act_wdt > 5'h12 && act_wdt < 5'h1F) |=>
    watchdog_divider_log2 == 5'h05 && !watchdog_sw_control) else $error("wdt fallback wrong");
  wdt_scaled_a: assert property ((act_wdt <= 5'h12) |=>
    watchdog_divider_log2 == 5'($past(act_wdt) + 5'h05)) else $error("wdt scale wrong");
  lvp_guard_a: assert property ((wr_wp && lvp_session) |=>
    stored_wp[13] == $past(stored_wp[13])) else $error("lvp cleared in lvp mode");
  reset_pin_a: assert property (act_wp[13] |=>
    external_reset_input_sel && !hv_program_entry_required) else $error("reset pin sel");
  hv_entry_a: assert property ((!act_wp[13] && !external_reset_pin_enable) |=>
    hv_program_entry_required && !external_reset_input_sel) else $error("hv entry");
  saf_wp_a: assert property (storage_area_write_protected == !$past(act_wp[11]))
    else $error("saf protect");
  ee_wp_a: assert property (eeprom_write_protected == !$past(act_wp[10]))
    else $error("eeprom protect");
  cfg_lock_a: assert property ((!stored_wp[9] && wr_cp) |-> 0)
    else $error("locked config written");
  bb_wp_a: assert property (boot_block_write_protected == !$past(act_wp[8]))
    else $error("boot protect");
  app_wp_a: assert property (application_write_protected == !$past(act_wp[7]))
    else $error("app protect");
  saf_en_a: assert property (storage_area_enabled == !$past(act_wp[4]))
    else $error("saf enable");
  bb_en_a: assert property (act_wp[3] |=> !boot_block_enabled &&
    boot_block_words == 16'h0000) else $error("boot enable");
  bb_lock_a: assert property ((wr_wp && !stored_wp[3]) |=>
    stored_wp[2:0] == $past(stored_wp[2:0])) else $error("size changed");
  bb_size_a: assert property ((!act_wp[3] && act_wp[2:0] == 3'h7) |=>
    boot_block_words == 16'h0200 && boot_block_last_addr == 16'h01FF) else $error("size");
  bb_half_a: assert property (boot_block_words <= HALF_WORDS)
    else $error("boot over half");
  sticky_wp_a: assert property ((!stored_wp[11] && !erase_go) |=> !stored_wp[11])
    else $error("protection undone");
  cp_on_a: assert property (!act_cp[0] |=> code_protect_enabled)
    else $error("code protect");
  rev_read_a: assert property ((setup && !pwrite && hit_rev) |=>
    pready && prdata[13:12] == 2'h2 && prdata[11:0] == {MAJOR_REV, MINOR_REV})
    else $error("revision word");
  id_read_a: assert property ((setup && !pwrite && hit_id) |=>
    pready && prdata[13:0] == {2'h3, PART_CODE}) else $error("identity word");
  latch_hold_a: assert property (!core_reset_hold |=> $stable(act_wp) && $stable(act_cp))
    else $error("latch moved");

  erase_c: cover property (erase_go);
  lvp_refuse_c: cover property (wr_wp && lvp_session && !pwdata[13]);
  bb_clamp_c: cover property (!bb_en_n && bb_sel_words > HALF_WORDS);
  cfg_lock_c: cover property (setup && pwrite && hit_wp && cfg_locked);
endmodule // cwp_config_protect
`default_nettype wire

// ==== verif/cwp_prog_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// device programmer: apb master and programming session
// ----------------------------------------------------------------------
module cwp_prog_model (
  input wire logic pclk, // bus clock
  input wire logic hv_req, // device asks for high voltage entry
  output logic psel, // apb select
  output logic penable, // apb enable
  output logic pwrite, // apb direction
  output logic [17:0] paddr, // apb byte address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  output logic lvp_session, // low-voltage session running
  output logic hv_applied // high voltage on the reset pin
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    lvp_session = 1'b0;
    hv_applied = 1'b0;
  end
  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [13:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {18'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~{18'h0, d}; // released data must not look valid
  endtask
  // without the low-voltage bit the programmer has to raise high voltage
  task automatic begin_session;
    @(posedge pclk);
    lvp_session <= !hv_req;
    hv_applied <= hv_req;
  endtask
  task automatic end_session;
    @(posedge pclk);
    lvp_session <= 1'b0;
    hv_applied <= 1'b0;
  endtask
endmodule // cwp_prog_model
`default_nettype wire

// ==== verif/cwp_config_protect_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module cwp_config_protect_tb;
  localparam int PW = 2048; // small memory so the half-size cap bites
  localparam logic [5:0] MAJ = 6'h2A; // arbitrary value
  localparam logic [5:0] MNR = 6'h15; // arbitrary value
  localparam logic [11:0] PID = 12'h6D3; // arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic core_reset_hold = 1'b0;
  logic ext_en = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, lvp_session, hv_applied, er;
  logic ers, hv, sawp, eewp, cfwp, bbwp, apwp, saen, boot_block_enable_n, cpen, wsw;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bbw, bbl;
  logic [4:0] wdl;
  logic [2:0] codes [3] = '{3'h7, 3'h6, 3'h0};
  int sz [3] = '{512, 1024, 1024};
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  wire logic [7:0] dec = {sawp, eewp, cfwp, bbwp, apwp, saen, boot_block_enable_n, cpen};
  always #5 pclk = ~pclk;
  cwp_config_protect #(.PROG_WORDS(PW), .MAJOR_REV(MAJ), .MINOR_REV(MNR), .PART_CODE(PID))
  i_cwp_config_protect (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lvp_session(lvp_session), .core_reset_hold(core_reset_hold),
    .external_reset_pin_enable(ext_en), .external_reset_input_sel(ers),
    .hv_program_entry_required(hv), .storage_area_write_protected(sawp),
    .eeprom_write_protected(eewp), .config_write_protected(cfwp),
    .boot_block_write_protected(bbwp), .application_write_protected(apwp),
    .storage_area_enabled(saen), .boot_block_enabled(boot_block_enable_n), .boot_block_words(bbw),
    .boot_block_last_addr(bbl), .code_protect_enabled(cpen),
    .watchdog_divider_log2(wdl), .watchdog_sw_control(wsw));
  cwp_prog_model i_cwp_prog_model (.pclk(pclk), .hv_req(hv), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lvp_session(lvp_session), .hv_applied(hv_applied));
  // ----------------------------------------------------------------------
  // checking and access tasks
  // ----------------------------------------------------------------------
  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] idx, input logic [13:0] d, input logic e);
    i_cwp_prog_model.xfer(w, idx, d, rd, er);
    chk({31'h0, er}, {31'h0, e});
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    i_cwp_prog_model.xfer(1'b0, idx, 14'h0, rd, er);
    chk(rd, exp);
  endtask
  // one cycle of device reset reloads the latched copies
  task automatic latch;
    @(posedge pclk) core_reset_hold <= 1'b1;
    @(posedge pclk) core_reset_hold <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // hang guard well above the expected few hundred cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'({ers, hv, dec}), 32'h0000_0200);
    i_cwp_prog_model.begin_session();
    rdc(cwp_pkg::REV_IDX, {18'h0, 2'b10, MAJ, MNR});
    rdc(cwp_pkg::ID_IDX, {18'h0, 2'b11, PID});
    rdc(cwp_pkg::WP_IDX, 32'h3FFF);
    acc(1'b0, 16'h8007, 14'h0, 1'b1);
    acc(1'b1, cwp_pkg::REV_IDX, 14'h0, 1'b1);
    for (int n = 0; n < 32; n++) begin
      acc(1'b1, cwp_pkg::WDT_IDX, n[13:0], 1'b0);
      latch();
      chk(32'(wdl), n <= 18 ? n + 5 : (n == 31 ? 16 : 5));
      chk(32'(wsw), 32'(n == 31));
    end
    acc(1'b1, cwp_pkg::WP_IDX, 14'h1FFF, 1'b0);
    rdc(cwp_pkg::WP_IDX, 32'h3FFF);
    latch();
    chk(32'({ers, hv}), 32'h0000_0002);
    i_cwp_prog_model.end_session();
    acc(1'b1, cwp_pkg::WP_IDX, 14'h1FFF, 1'b0);
    rdc(cwp_pkg::WP_IDX, 32'h1FFF);
    latch();
    chk(32'({ers, hv}), 32'h0000_0001);
    // with the low-voltage bit cleared the programmer must enter on high voltage
    i_cwp_prog_model.begin_session();
    #1 chk(32'({lvp_session, hv_applied}), 32'h0000_0001);
    i_cwp_prog_model.end_session();
    @(posedge pclk) ext_en <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(32'(ers), 1);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, cwp_pkg::ERASE_IDX, 14'h0001, 1'b0);
      acc(1'b1, cwp_pkg::WP_IDX, {11'h7FE, codes[i]}, 1'b0);
      acc(1'b1, cwp_pkg::WP_IDX, 14'h3FFF, 1'b0);
      rdc(cwp_pkg::WP_IDX, {18'h0, 11'h7FE, codes[i]});
      latch();
      chk(32'(bbw), sz[i]);
      chk(32'(bbl), sz[i] - 1);
      chk(32'(boot_block_enable_n), 1);
    end
    acc(1'b1, cwp_pkg::ERASE_IDX, 14'h0001, 1'b0);
    latch();
    chk({bbw, bbl}, 32'h0);
    // protections land only when the latched copies reload
    acc(1'b1, cwp_pkg::CP_IDX, 14'h3FFE, 1'b0);
    acc(1'b1, cwp_pkg::WP_IDX, 14'h326F, 1'b0);
    chk(32'(dec), 0);
    latch();
    chk(32'(dec), 32'hDD);
    acc(1'b1, cwp_pkg::WP_IDX, 14'h306F, 1'b0);
    latch();
    chk(32'(cfwp), 1);
    acc(1'b1, cwp_pkg::CP_IDX, 14'h3FFF, 1'b1);
    acc(1'b1, cwp_pkg::WDT_IDX, 14'h0000, 1'b1);
    rdc(cwp_pkg::CP_IDX, 32'h3FFE);
    acc(1'b1, cwp_pkg::ERASE_IDX, 14'h0001, 1'b0);
    rdc(cwp_pkg::WP_IDX, 32'h3FFF);
    latch();
    chk(32'(dec), 0);
    close_out();
  end
endmodule // cwp_config_protect_tb
`default_nettype wire
